// ### include/iocnpr_pkg.sv
package iocnpr_pkg;

  // Port geometry.
  localparam int unsigned pin_count     = 16;
  localparam int unsigned cn_count      = 21;
  localparam int unsigned cn_low_count  = 16;
  localparam int unsigned cn_high_count = 5;
  localparam int unsigned sel_width     = 5;
  localparam int unsigned in_sel_count  = 19;
  localparam int unsigned out_idx_width = 4;

  // Bits built on this variant; the others are dead and read as zero in direction, latch, open drain and pin view.
  localparam logic [15:0] impl_mask      = 16'h7fff;
  // Pins that share an analog input channel.
  localparam logic [15:0] analog_capable = 16'h003f;

  // Reset values.
  localparam logic [15:0] dir_reset     = impl_mask;
  localparam logic [15:0] latch_reset   = 16'h0000;
  localparam logic [15:0] odc_reset     = 16'h0000;
  localparam logic [15:0] anacfg_reset  = 16'h0000;
  localparam logic [15:0] cn_low_reset  = 16'h0000;
  localparam logic [4:0]  cn_high_reset = 5'h00;
  localparam logic [4:0]  in_sel_reset  = 5'h1f;
  localparam logic [4:0]  out_sel_reset = 5'h00;

  // Output selector codes.
  localparam logic [4:0] code_null      = 5'h00;
  localparam logic [4:0] code_uart_tx   = 5'h03;
  localparam logic [4:0] code_uart_rts  = 5'h04;
  localparam logic [4:0] code_spi_data  = 5'h07;
  localparam logic [4:0] code_spi_clock = 5'h08;
  localparam logic [4:0] code_spi_sel   = 5'h09;
  localparam logic [4:0] code_cmp_one   = 5'h12;
  localparam logic [4:0] code_cmp_two   = 5'h13;
  localparam logic [4:0] code_quad_dir  = 5'h1a;

  // Route lock sequence on the low byte of the oscillator control register.
  localparam logic [7:0] unlock_key_one = 8'h46;
  localparam logic [7:0] unlock_key_two = 8'h57;
  localparam int unsigned lock_bit_pos  = 6;

  typedef enum logic [1:0] {
    unlock_idle,
    unlock_armed,
    unlock_open
  } iocnpr_unlock_type;

endpackage

// ### hw/iocnpr_top.sv
// How it works
// - A peripheral actively driving a shared pin disables the port driver; pin still readable.
// - A pin driven by its own port output never feeds a routed peripheral input.
// - Direction bit one means input, zero means output; all implemented bits reset to input.
// - Latch reads latch, pin view reads pins, writes to either update latch.
// - Unimplemented bits read zero in latch, direction and pin view, and never drive.
// - Open-drain select makes a pin drive low only, floating when high.
// - Analog configuration resets to zero so analog-capable pins start analog.
// - Pins in analog mode read low in the pin view.
// - Any enabled change-notify input change raises an interrupt request.
// - Twenty-one change-notify inputs each have an enable bit over two registers.
// - Each change-notify pin has a weak pull-up enable over two registers.
// - Routing covers sixteen remappable pins numbered zero to fifteen.
// - Each routed peripheral input has a 5-bit selector naming its pin.
// - Input routing does not override direction; software sets the pin to input.
// - Nineteen input selectors exist for interrupts, timers, captures, faults, quadrature, serial, SPI.
// - Each remappable pin has a 5-bit output selector choosing its peripheral.
// - Output code zero leaves the pin under default port logic.
// - Codes 00011, 00100, 00111 route serial transmit, request-to-send, SPI data.
// - Codes 01000 and 01001 route SPI clock and SPI select outputs.
// - Codes 10010, 10011 route compares one and two; 11010 quadrature direction.
// - Selector writes are ignored while locked; lock changes only after 0x46 then 0x57.
// - Shadow copies watch all selectors; any mismatch raises a configuration mismatch reset.
// - With single-session lock set, the lock cannot be cleared once set until reset.
// - Input selectors reset to all ones; 11111 ties the peripheral input low.
module iocnpr_top (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        dir_wr,
  input  wire logic [15:0] dir_wdata,
  input  wire logic        latch_wr,
  input  wire logic [15:0] latch_wdata,
  input  wire logic        view_wr,
  input  wire logic [15:0] view_wdata,
  input  wire logic        odc_wr,
  input  wire logic [15:0] odc_wdata,
  input  wire logic        anacfg_wr,
  input  wire logic [15:0] anacfg_wdata,
  input  wire logic        cnen_low_wr,
  input  wire logic [15:0] cnen_low_wdata,
  input  wire logic        cnen_high_wr,
  input  wire logic [4:0]  cnen_high_wdata,
  input  wire logic        pu_low_wr,
  input  wire logic [15:0] pu_low_wdata,
  input  wire logic        pu_high_wr,
  input  wire logic [4:0]  pu_high_wdata,
  input  wire logic        osc_low_wr,
  input  wire logic [7:0]  osc_low_wdata,
  input  wire logic        single_session_lock,
  input  wire logic        in_sel_wr,
  input  wire logic [4:0]  in_sel_idx,
  input  wire logic [4:0]  in_sel_wdata,
  input  wire logic        out_sel_wr,
  input  wire logic [3:0]  out_sel_idx,
  input  wire logic [4:0]  out_sel_wdata,
  input  wire logic [15:0] pin_in,
  input  wire logic [20:0] change_notify_pin_in,
  input  wire logic [15:0] periph_drive_en,
  input  wire logic [15:0] periph_drive_data,
  input  wire logic        serial_transmit_out,
  input  wire logic        serial_request_to_send_out,
  input  wire logic        spi_data_out,
  input  wire logic        spi_clock_out,
  input  wire logic        spi_select_out,
  input  wire logic        compare_one_out,
  input  wire logic        compare_two_out,
  input  wire logic        quadrature_direction_status,
  output logic      [15:0] pin_direction_bits,
  output logic      [15:0] output_latch,
  output logic      [15:0] pin_level_view,
  output logic      [15:0] open_drain_select,
  output logic      [15:0] analog_pin_config,
  output logic      [15:0] change_irq_enable_low,
  output logic      [4:0]  change_irq_enable_high,
  output logic      [15:0] weak_pullup_enable_low,
  output logic      [4:0]  weak_pullup_enable_high,
  output logic             route_lock_bit,
  output logic      [15:0] pin_out,
  output logic      [15:0] pin_oe_n,
  output logic      [18:0] routed_in,
  output logic             change_notify_irq,
  output logic             config_mismatch_reset
);

  // Control registers.
  logic [15:0] dir_q;
  logic [15:0] latch_q;
  logic [15:0] odc_q;
  logic [15:0] anacfg_q;
  logic [15:0] cnen_low_q;
  logic [4:0]  cnen_high_q;
  logic [15:0] pu_low_q;
  logic [4:0]  pu_high_q;
  logic        lock_q;
  logic        lock_set_once_q;
  iocnpr_pkg::iocnpr_unlock_type unlock_q;
  iocnpr_pkg::iocnpr_unlock_type unlock_d;

  // Routing selectors and their shadows.
  logic [4:0] in_sel_q   [iocnpr_pkg::in_sel_count];
  logic [4:0] in_shad_q  [iocnpr_pkg::in_sel_count];
  logic [4:0] out_sel_q  [iocnpr_pkg::pin_count];
  logic [4:0] out_shad_q [iocnpr_pkg::pin_count];

  // Synchronisers.
  logic [15:0] pin_meta_q;
  logic [15:0] pin_sync_q;
  logic [20:0] cn_meta_q;
  logic [20:0] cn_sync_q;
  logic [20:0] cn_prev_q;

  // Decode and datapath wires.
  logic [15:0] port_drive;
  logic [15:0] pin_out_d;
  logic [15:0] pin_oe_n_d;
  logic [15:0] view_d;
  logic [15:0] analog_active;
  logic [18:0] routed_d;
  logic [15:0] remap_owned;
  logic [15:0] remap_data;
  logic [18:0] in_mismatch;
  logic [15:0] out_mismatch;
  logic [20:0] cn_enable_all;
  logic [20:0] cn_change;
  logic        sel_wr_allowed;
  logic        in_wr_hit;
  logic        lock_wr_now;
  logic        lock_new;
  logic        lock_d;

  // Locked selector writes appear to complete but leave the contents alone.
  assign sel_wr_allowed = !lock_q;
  assign in_wr_hit      = in_sel_wr && sel_wr_allowed
                          && (in_sel_idx < 5'(iocnpr_pkg::in_sel_count));

  // The first write after the two keys, the third of the sequence, is the only one that may move the lock.
  assign lock_wr_now = osc_low_wr && (unlock_q == iocnpr_pkg::unlock_open);
  assign lock_new    = osc_low_wdata[iocnpr_pkg::lock_bit_pos];
  assign lock_d      = (lock_wr_now && !(single_session_lock && lock_set_once_q && !lock_new))
                       ? lock_new : lock_q;

  always_comb begin
    unlock_d = unlock_q;
    if (osc_low_wr) begin
      unique case (unlock_q)
        iocnpr_pkg::unlock_idle: begin
          unlock_d = (osc_low_wdata == iocnpr_pkg::unlock_key_one)
                     ? iocnpr_pkg::unlock_armed : iocnpr_pkg::unlock_idle;
        end
        iocnpr_pkg::unlock_armed: begin
          unlock_d = (osc_low_wdata == iocnpr_pkg::unlock_key_two)
                     ? iocnpr_pkg::unlock_open : iocnpr_pkg::unlock_idle;
        end
        iocnpr_pkg::unlock_open: begin
          unlock_d = iocnpr_pkg::unlock_idle;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      unlock_q        <= iocnpr_pkg::unlock_idle;
      lock_q          <= 1'b0;
      lock_set_once_q <= 1'b0;
    end else begin
      unlock_q        <= unlock_d;
      lock_q          <= lock_d;
      lock_set_once_q <= lock_set_once_q | lock_d;
    end
  end

  // Port registers; dead bits of direction, latch and open drain are masked on the way in so they read zero.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      dir_q       <= iocnpr_pkg::dir_reset;
      latch_q     <= iocnpr_pkg::latch_reset;
      odc_q       <= iocnpr_pkg::odc_reset;
      anacfg_q    <= iocnpr_pkg::anacfg_reset;
      cnen_low_q  <= iocnpr_pkg::cn_low_reset;
      cnen_high_q <= iocnpr_pkg::cn_high_reset;
      pu_low_q    <= iocnpr_pkg::cn_low_reset;
      pu_high_q   <= iocnpr_pkg::cn_high_reset;
    end else begin
      if (dir_wr) begin
        dir_q <= dir_wdata & iocnpr_pkg::impl_mask;
      end
      if (latch_wr) begin
        latch_q <= latch_wdata & iocnpr_pkg::impl_mask;
      end else if (view_wr) begin
        latch_q <= view_wdata & iocnpr_pkg::impl_mask;
      end
      if (odc_wr) begin
        odc_q <= odc_wdata & iocnpr_pkg::impl_mask;
      end
      if (anacfg_wr) begin
        anacfg_q <= anacfg_wdata;
      end
      if (cnen_low_wr) begin
        cnen_low_q <= cnen_low_wdata;
      end
      if (cnen_high_wr) begin
        cnen_high_q <= cnen_high_wdata;
      end
      if (pu_low_wr) begin
        pu_low_q <= pu_low_wdata;
      end
      if (pu_high_wr) begin
        pu_high_q <= pu_high_wdata;
      end
    end
  end

  // Selectors and shadows are written together by the same legal write only.
  // Anything that disturbs one copy alone shows up as a mismatch.
  genvar gi;
  generate
    for (gi = 0; gi < iocnpr_pkg::in_sel_count; gi++) begin : g_in_sel
      always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
          in_sel_q[gi]  <= iocnpr_pkg::in_sel_reset;
          in_shad_q[gi] <= iocnpr_pkg::in_sel_reset;
        end else if (in_wr_hit && (in_sel_idx == 5'(gi))) begin
          in_sel_q[gi]  <= in_sel_wdata;
          in_shad_q[gi] <= in_sel_wdata;
        end
      end
      assign in_mismatch[gi] = (in_sel_q[gi] != in_shad_q[gi]);
      // Codes 16 and above, including all ones, tie the input low.
      assign routed_d[gi] = (in_sel_q[gi][4] == 1'b0)
                            && pin_sync_q[in_sel_q[gi][3:0]]
                            && !port_drive[in_sel_q[gi][3:0]];
    end

    for (gi = 0; gi < iocnpr_pkg::pin_count; gi++) begin : g_pin
      always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
          out_sel_q[gi]  <= iocnpr_pkg::out_sel_reset;
          out_shad_q[gi] <= iocnpr_pkg::out_sel_reset;
        end else if (out_sel_wr && sel_wr_allowed && (out_sel_idx == 4'(gi))) begin
          out_sel_q[gi]  <= out_sel_wdata;
          out_shad_q[gi] <= out_sel_wdata;
        end
      end
      assign out_mismatch[gi] = (out_sel_q[gi] != out_shad_q[gi]);

      // Peripheral output chosen by this pin's code; unknown codes own nothing.
      always_comb begin
        remap_owned[gi] = 1'b1;
        unique case (out_sel_q[gi])
          iocnpr_pkg::code_uart_tx:   remap_data[gi] = serial_transmit_out;
          iocnpr_pkg::code_uart_rts:  remap_data[gi] = serial_request_to_send_out;
          iocnpr_pkg::code_spi_data:  remap_data[gi] = spi_data_out;
          iocnpr_pkg::code_spi_clock: remap_data[gi] = spi_clock_out;
          iocnpr_pkg::code_spi_sel:   remap_data[gi] = spi_select_out;
          iocnpr_pkg::code_cmp_one:   remap_data[gi] = compare_one_out;
          iocnpr_pkg::code_cmp_two:   remap_data[gi] = compare_two_out;
          iocnpr_pkg::code_quad_dir:  remap_data[gi] = quadrature_direction_status;
          default: begin
            remap_owned[gi] = 1'b0;
            remap_data[gi]  = 1'b0;
          end
        endcase
      end

      // The port only drives when no peripheral holds the pin and the direction bit says output.
      assign port_drive[gi] = iocnpr_pkg::impl_mask[gi] && !remap_owned[gi]
                              && !periph_drive_en[gi] && !dir_q[gi];

      // Open drain trades a high drive for letting an external pull-up set the level.
      always_comb begin
        pin_out_d[gi]  = 1'b0;
        pin_oe_n_d[gi] = 1'b1;
        if (!iocnpr_pkg::impl_mask[gi]) begin
          pin_oe_n_d[gi] = 1'b1;
        end else if (remap_owned[gi]) begin
          pin_out_d[gi]  = remap_data[gi] & !odc_q[gi];
          pin_oe_n_d[gi] = odc_q[gi] & remap_data[gi];
        end else if (periph_drive_en[gi]) begin
          pin_out_d[gi]  = periph_drive_data[gi] & !odc_q[gi];
          pin_oe_n_d[gi] = odc_q[gi] & periph_drive_data[gi];
        end else if (port_drive[gi]) begin
          pin_out_d[gi]  = latch_q[gi] & !odc_q[gi];
          pin_oe_n_d[gi] = odc_q[gi] & latch_q[gi];
        end
      end
    end
  endgenerate

  // Analog-capable pins stay analog until their configuration bit is set.
  assign analog_active = iocnpr_pkg::analog_capable & ~anacfg_q;
  assign view_d        = pin_sync_q & iocnpr_pkg::impl_mask & ~analog_active;

  // Change notification compares synchronised samples one cycle apart.
  // This logic needs mclk; wake from Sleep relies on the system keeping it running here.
  assign cn_enable_all = {cnen_high_q, cnen_low_q};
  assign cn_change     = (cn_sync_q ^ cn_prev_q) & cn_enable_all;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pin_meta_q <= 16'h0000;
      pin_sync_q <= 16'h0000;
      cn_meta_q  <= 21'h000000;
      cn_sync_q  <= 21'h000000;
      cn_prev_q  <= 21'h000000;
    end else begin
      pin_meta_q <= pin_in;
      pin_sync_q <= pin_meta_q;
      cn_meta_q  <= change_notify_pin_in;
      cn_sync_q  <= cn_meta_q;
      cn_prev_q  <= cn_sync_q;
    end
  end

  // Every output comes from a flop so the pins see no decode glitches.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pin_out               <= 16'h0000;
      pin_oe_n              <= 16'hffff;
      pin_level_view        <= 16'h0000;
      routed_in             <= 19'h00000;
      change_notify_irq     <= 1'b0;
      config_mismatch_reset <= 1'b0;
    end else begin
      pin_out               <= pin_out_d;
      pin_oe_n              <= pin_oe_n_d;
      pin_level_view        <= view_d;
      routed_in             <= routed_d;
      change_notify_irq     <= |cn_change;
      config_mismatch_reset <= (|in_mismatch) | (|out_mismatch);
    end
  end

  assign pin_direction_bits      = dir_q;
  assign output_latch            = latch_q;
  assign open_drain_select       = odc_q;
  assign analog_pin_config       = anacfg_q;
  assign change_irq_enable_low   = cnen_low_q;
  assign change_irq_enable_high  = cnen_high_q;
  assign weak_pullup_enable_low  = pu_low_q;
  assign weak_pullup_enable_high = pu_high_q;
  assign route_lock_bit          = lock_q;

endmodule

// ### tb/iocnpr_pad_model.sv
module iocnpr_pad_model (
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe_n,
  input  wire logic [15:0] ext_en,
  input  wire logic [15:0] ext_val,
  output logic      [15:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // Every pad carries a board pull-up, so a released pad settles high instead of keeping its last value.
  // The device driver wins over the board so that a brief overlap during a direction change stays defined.
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      pin_level[i] = !pin_oe_n[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
    end
  end
endmodule

// ### tb/iocnpr_assertions.sv
module iocnpr_assertions (
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        dir_wr,
  input wire logic [15:0] dir_wdata,
  input wire logic        latch_wr,
  input wire logic [15:0] latch_wdata,
  input wire logic        view_wr,
  input wire logic [15:0] view_wdata,
  input wire logic        osc_low_wr,
  input wire logic [7:0]  osc_low_wdata,
  input wire logic        single_session_lock,
  input wire logic [15:0] pin_in,
  input wire logic [15:0] pin_direction_bits,
  input wire logic [15:0] output_latch,
  input wire logic [15:0] pin_level_view,
  input wire logic [15:0] open_drain_select,
  input wire logic [15:0] analog_pin_config,
  input wire logic [15:0] change_irq_enable_low,
  input wire logic [4:0]  change_irq_enable_high,
  input wire logic        route_lock_bit,
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe_n,
  input wire logic        change_notify_irq,
  input wire logic        config_mismatch_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  logic [1:0]  up_q;
  logic [1:0]  quiet_q;
  logic [15:0] digital_mask;
  assign digital_mask = iocnpr_pkg::impl_mask & (analog_pin_config | ~iocnpr_pkg::analog_capable);
  // The synchronisers restart empty after reset, so the pin view is only compared once they are refilled.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      up_q    <= 2'h0;
      quiet_q <= 2'h0;
    end else begin
      up_q    <= (up_q == 2'h3) ? up_q : up_q + 2'h1;
      quiet_q <= (|{change_irq_enable_low, change_irq_enable_high}) ? 2'h0 :
                 (quiet_q == 2'h3) ? quiet_q : quiet_q + 2'h1;
    end
  end
  sequence s_unlock;
    (osc_low_wr && osc_low_wdata == iocnpr_pkg::unlock_key_one) ##1 !osc_low_wr ##1
    (osc_low_wr && osc_low_wdata == iocnpr_pkg::unlock_key_two) ##1 !osc_low_wr;
  endsequence
  a_dir_write: assert property (dir_wr |=> pin_direction_bits == ($past(dir_wdata) & iocnpr_pkg::impl_mask))
    else $error("direction readback does not follow its write");
  a_latch_write: assert property (latch_wr |=> output_latch == ($past(latch_wdata) & iocnpr_pkg::impl_mask))
    else $error("latch does not follow a latch write");
  a_view_write: assert property (
    view_wr && !latch_wr |=> output_latch == ($past(view_wdata) & iocnpr_pkg::impl_mask))
    else $error("latch does not follow a pin view write");
  a_dead_bits: assert property (
    ((pin_direction_bits | output_latch | pin_level_view | ~pin_oe_n) & ~iocnpr_pkg::impl_mask) == 16'h0)
    else $error("an unimplemented bit reads nonzero or drives");
  a_view_pins: assert property (
    up_q == 2'h3 && $stable(analog_pin_config) |-> pin_level_view == ($past(pin_in, 3) & digital_mask))
    else $error("pin view differs from synchronised pins");
  a_open_drain: assert property ((open_drain_select & $past(open_drain_select) & ~pin_oe_n & pin_out) == 16'h0)
    else $error("open drain pin drives high");
  a_irq_quiet: assert property (quiet_q == 2'h3 |-> !change_notify_irq)
    else $error("change interrupt with all enables clear");
  a_lock_set: assert property (s_unlock ##1 (osc_low_wr && osc_low_wdata[6]) |-> ##[1:2] route_lock_bit)
    else $error("lock not set after unlock sequence");
  a_lock_clear: assert property (
    s_unlock ##1 (osc_low_wr && !osc_low_wdata[6] && !single_session_lock) |-> ##[1:2] !route_lock_bit)
    else $error("lock not cleared after unlock sequence");
  a_lock_cause: assert property ($changed(route_lock_bit) |-> $past(osc_low_wr))
    else $error("lock changed without a control byte write");
  a_lock_oneway: assert property (route_lock_bit && single_session_lock |=> route_lock_bit)
    else $error("single session lock was cleared");
  a_no_mismatch: assert property (!config_mismatch_reset)
    else $error("selector shadow mismatch reported");
endmodule
bind iocnpr_top iocnpr_assertions u_iocnpr_assertions (
  .mclk, .reset, .dir_wr, .dir_wdata, .latch_wr, .latch_wdata, .view_wr, .view_wdata, .osc_low_wr, .osc_low_wdata,
  .single_session_lock, .pin_in, .pin_direction_bits, .output_latch, .pin_level_view, .open_drain_select,
  .analog_pin_config, .change_irq_enable_low, .change_irq_enable_high, .route_lock_bit, .pin_out, .pin_oe_n,
  .change_notify_irq, .config_mismatch_reset);

// ### tb/tb_top.sv
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin mismatches++; \
  $display("ERROR %s expected %h seen %h", nm, ex, gt); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic [11:0] st = '0;
  logic [15:0] wd = '0;
  logic        ssl = 1'b0;
  logic [7:0]  po = '0;
  logic [15:0] pde = '0, pdd = 16'hfffd, ext_en = '0, ext_val = '0;
  logic [20:0] cnp = '0;
  logic [15:0] dirb, lat, view, odc, ana, cnl, pul, pout, poen, pin;
  logic [4:0]  cnh, puh;
  logic [18:0] rin;
  logic        lock, irq, mism;
  int          mismatches = 0, cmp_count = 0, n;
  logic [4:0]  codes [8] = '{iocnpr_pkg::code_uart_tx, iocnpr_pkg::code_uart_rts, iocnpr_pkg::code_spi_data,
    iocnpr_pkg::code_spi_clock, iocnpr_pkg::code_spi_sel, iocnpr_pkg::code_cmp_one, iocnpr_pkg::code_cmp_two,
    iocnpr_pkg::code_quad_dir};
  always #20 mclk = ~mclk;
  iocnpr_top u_iocnpr_top (.mclk(mclk), .reset(reset), .dir_wr(st[0]), .dir_wdata(wd), .latch_wr(st[1]),
    .latch_wdata(wd), .view_wr(st[2]), .view_wdata(wd), .odc_wr(st[3]), .odc_wdata(wd), .anacfg_wr(st[4]),
    .anacfg_wdata(wd), .cnen_low_wr(st[5]), .cnen_low_wdata(wd), .cnen_high_wr(st[6]), .cnen_high_wdata(wd[4:0]),
    .pu_low_wr(st[7]), .pu_low_wdata(wd), .pu_high_wr(st[8]), .pu_high_wdata(wd[4:0]), .osc_low_wr(st[9]),
    .osc_low_wdata(wd[7:0]), .single_session_lock(ssl), .in_sel_wr(st[10]), .in_sel_idx(wd[12:8]),
    .in_sel_wdata(wd[4:0]), .out_sel_wr(st[11]), .out_sel_idx(wd[11:8]), .out_sel_wdata(wd[4:0]), .pin_in(pin),
    .change_notify_pin_in(cnp), .periph_drive_en(pde), .periph_drive_data(pdd), .serial_transmit_out(po[0]),
    .serial_request_to_send_out(po[1]), .spi_data_out(po[2]), .spi_clock_out(po[3]), .spi_select_out(po[4]),
    .compare_one_out(po[5]), .compare_two_out(po[6]), .quadrature_direction_status(po[7]),
    .pin_direction_bits(dirb), .output_latch(lat), .pin_level_view(view), .open_drain_select(odc),
    .analog_pin_config(ana), .change_irq_enable_low(cnl), .change_irq_enable_high(cnh),
    .weak_pullup_enable_low(pul), .weak_pullup_enable_high(puh), .route_lock_bit(lock), .pin_out(pout),
    .pin_oe_n(poen), .routed_in(rin), .change_notify_irq(irq), .config_mismatch_reset(mism));
  iocnpr_pad_model u_iocnpr_pad_model (.pin_out(pout), .pin_oe_n(poen), .ext_en(ext_en), .ext_val(ext_val),
    .pin_level(pin));
  task automatic cyc(input int k);
    repeat (k) @(negedge mclk);
  endtask
  // Strobes drop one cycle after they rise, so back-to-back calls always leave an idle cycle.
  task automatic wr(input int k, input logic [15:0] d);
    @(negedge mclk);
    st[k] = 1'b1;
    wd = d;
    @(negedge mclk);
    st = '0;
  endtask
  task automatic lk(input logic [7:0] v);
    wr(9, 16'h0046);
    wr(9, 16'h0057);
    wr(9, {8'h00, v});
    cyc(1);
  endtask
  task automatic irqs(output int c);
    c = 0;
    repeat (8) begin
      @(negedge mclk);
      if (irq !== 1'b0) c++;
    end
  endtask
  task automatic tend(input string s);
    $display("TB: test %s finished, %0d mismatches so far", s, mismatches);
  endtask
  task automatic report_and_stop;
    $display("TB: %0d comparisons, %0d mismatches", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge mclk);
    mismatches++;
    $display("ERROR watchdog expected finish seen timeout");
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    reset = 1'b0;
    `CHK("dir", iocnpr_pkg::dir_reset, dirb)
    `CHK("analog", 16'h0000, ana)
    `CHK("cn_pu", 42'h0, {cnl, cnh, pul, puh})
    `CHK("oe", 16'hffff, poen)
    `CHK("routed", 19'h0, rin)
    tend("reset");
    wr(0, 16'h0000);
    `CHK("dir", 16'h0000, dirb)
    wr(1, 16'hffff);
    `CHK("latch", 16'h7fff, lat)
    cyc(6);
    `CHK("view", 16'h7fc0, view)
    wr(2, 16'h2aaa);
    wr(4, 16'hffff);
    `CHK("analog", 16'hffff, ana)
    cyc(6);
    `CHK("latch", 16'h2aaa, lat)
    `CHK("view", 16'h2aaa, view)
    `CHK("oe", 16'h8000, poen)
    wr(3, 16'hffff);
    `CHK("odc", 16'h7fff, odc)
    cyc(6);
    `CHK("od_oe", 16'haaaa, poen)
    `CHK("od_low", 16'h0, pout & ~poen)
    `CHK("od_view", 16'h2aaa, view)
    wr(3, 16'h0000);
    pde = 16'h0002;
    cyc(6);
    `CHK("periph", 3'h0, {poen[1], pout[1], view[1]})
    pde = '0;
    tend("port");
    wr(0, 16'h0004);
    foreach (codes[i]) begin
      wr(11, {8'h02, 3'b000, codes[i]});
      po = 8'h01 << i;
      cyc(2);
      `CHK("route_hi", 2'b01, {poen[2], pout[2]})
      po = ~(8'h01 << i);
      cyc(2);
      `CHK("route_lo", 2'b00, {poen[2], pout[2]})
    end
    po = 8'hff;
    wr(11, {8'h02, 3'b000, iocnpr_pkg::code_null});
    cyc(2);
    `CHK("null", 1'b1, poen[2])
    wr(11, 16'h0205);
    cyc(2);
    `CHK("unused", 1'b1, poen[2])
    for (int i = 0; i < 19; i++) wr(10, {3'b000, i[4:0], 8'h09});
    cyc(4);
    `CHK("loop", 19'h0, rin)
    ext_en = 16'h0200;
    ext_val = 16'h0200;
    wr(0, 16'h0204);
    cyc(4);
    `CHK("route_in", 19'h7ffff, rin)
    ext_val = 16'h0000;
    cyc(5);
    `CHK("route_in", 19'h0, rin)
    ext_val = 16'h0200;
    wr(10, {3'b000, 5'd14, 8'h1f});
    cyc(4);
    `CHK("tied", 19'h7bfff, rin)
    tend("route");
    lk(8'h40);
    `CHK("lock", 1'b1, lock)
    wr(10, 16'h001f);
    cyc(4);
    `CHK("locked", 19'h7bfff, rin)
    lk(8'h00);
    `CHK("lock", 1'b0, lock)
    wr(9, 16'h0046);
    wr(9, 16'h0012);
    wr(9, 16'h0040);
    cyc(1);
    `CHK("badkey", 1'b0, lock)
    ssl = 1'b1;
    lk(8'h40);
    lk(8'h00);
    `CHK("oneway", 1'b1, lock)
    tend("lock");
    cnp[4] = 1'b1;
    irqs(n);
    `CHK("irq_none", 0, n)
    wr(5, 16'h0008);
    wr(6, 16'h0010);
    wr(7, 16'h00ff);
    wr(8, 16'h001f);
    `CHK("cn_en", 21'h000110, {cnl, cnh})
    `CHK("pullup", 21'h001fff, {pul, puh})
    cnp[4] = 1'b0;
    irqs(n);
    `CHK("irq_off", 0, n)
    cnp[3] = 1'b1;
    irqs(n);
    `CHK("irq_rise", 1, n)
    cnp[20] = 1'b1;
    irqs(n);
    `CHK("irq_high", 1, n)
    cnp[3] = 1'b0;
    irqs(n);
    `CHK("irq_fall", 1, n)
    tend("notify");
    report_and_stop();
  end
endmodule
